// File: rtl/lnc_map.vh
`ifndef LNC_MAP_VH
`define LNC_MAP_VH
// Functional notes
// [R1] address phase: low 16 on bus, 8 high
// [R2] inbound control low in read data phase
// [R3] outbound control low: read address, whole write
// [R4] strobe high in address, low in data
// [R5] wait acknowledge high before requesting again
// [R6] hold request low whole transaction, ack grants
// [R7] bus config bit 0 picks pin function
// [R8] sense request line high before pulling low
// [R9] interrupt pin active: flag set and enabled
// [R10] read/write line direction, master versus slave
// [R11] memory ready acknowledges master transfers
// [R12] slave ready until strobe returns high
// [R13] reset: stop, clear, float, stop bit set
// [R14] transmit enable only with valid frame bits
// [R15] bits timed by transmit and receive clocks
// [R16] status bit 7 shows interrupt condition
// [R17] six interrupt sources raised by events
// [R18] preamble, delimiter, data, then 32-bit CRC
// [R19] preamble starts once first byte buffered
// [R20] 64-byte receive buffer, CRC error bit
// [R21] physical match on full 48-bit address
// [R22] hash group, broadcast or promiscuous accept
// [R23] standard Ethernet CRC polynomial and order
// [R24] port select picks pointer or data register

// --------
// timing
// --------
`define LNC_CLK_NS      8
`define LNC_TMO_NS      25600
`define LNC_TMO_CYC     ((`LNC_TMO_NS) / (`LNC_CLK_NS))

// --------
// register indexes and fields
// --------
`define LNC_IDX_MAIN_CONTROL_STATUS_REG    2'h0
`define LNC_IDX_BUS_CONFIG_REG    2'h3
`define LNC_B_INIT      0
`define LNC_B_STRT      1
`define LNC_B_STOP      2
`define LNC_B_TDMD      3
`define LNC_B_IEN       6
`define LNC_B_IRQ_OUT_N      7
`define LNC_B_FLAG      8
`define LNC_B_BUS_PIN_CONFIG_BIT      0
`define LNC_BUS_CONFIG_REG_RST    1'h0
`define LNC_STOP_RST    1'h1

// --------
// frame constants
// --------
`define LNC_PRE         8'h55
`define LNC_SFD         8'hD5
`define LNC_POLY        32'hEDB88320
`define LNC_RESID       32'hDEBB20E3
`define LNC_MAX_LEN     11'h5EE
`define LNC_TXF_DEPTH   6'h30
`endif

// File: rtl/lnc_crc32.v
`include "lnc_map.vh"
module lnc_crc32 (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  input  wire        ce,
  // bit stream
  input  wire        init,
  input  wire        en,
  input  wire        din,
  // result
  output reg  [31:0] crc_q,
  output wire [31:0] crc_nxt
);
  // reflected, lsb first, preset all ones (see [R23])
  assign crc_nxt = {1'b0, crc_q[31:1]} ^ ((crc_q[0] ^ din) ? `LNC_POLY : 32'h0);

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      crc_q <= 32'hFFFFFFFF;
    else if (ce)
    begin
      if (init)
        crc_q <= 32'hFFFFFFFF;
      else if (en)
        crc_q <= crc_nxt;
    end
  end
endmodule // lnc_crc32

// File: rtl/lnc_buf2.v
module lnc_buf2 (
  // clock and reset
  input  wire       clock,
  input  wire       rstn,
  input  wire       ce,
  // fill side
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_data,
  // drain side
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data
);
  reg [7:0] e0_q;
  reg [7:0] e1_q;
  reg [1:0] cnt_q;
  wire      push = in_valid && in_ready;
  wire      pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = e0_q;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      e0_q  <= 8'h00;
      e1_q  <= 8'h00;
      cnt_q <= 2'h0;
    end
    else if (ce)
    begin
      // e0 is always the head; e1 shifts down on a pop
      if (pop)
        e0_q <= (cnt_q == 2'h2) ? e1_q : in_data;
      else if (push && cnt_q == 2'h0)
        e0_q <= in_data;
      if (push && (cnt_q == 2'h2 || (cnt_q == 2'h1 && !pop)))
        e1_q <= in_data;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // lnc_buf2

// File: rtl/lnc_top.v
`include "lnc_map.vh"
module lnc_top (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  input  wire        ce,
  // multiplexed bus
  input  wire [15:0] muxed_addr_data_bus_i,
  output wire [15:0] muxed_addr_data_bus_o,
  output wire        muxed_addr_data_bus_oe_n,
  output wire [7:0]  high_address_lines,
  output wire        xcvr_inbound_ctl,
  output wire        xcvr_outbound_ctl,
  output wire        master_ctl_oe_n,
  input  wire        rw_i,
  output wire        rw_o,
  input  wire        data_strobe_n_i,
  output wire        data_strobe_n_o,
  input  wire        ready_n_i,
  output wire        ready_n_o,
  output wire        ready_n_oe_n,
  // slave select
  input  wire        chip_select_n,
  input  wire        port_sel,
  // arbitration
  input  wire        chain_bus_request_n_i,
  output wire        chain_bus_request_n_o,
  output wire        chain_bus_request_n_oe_n,
  input  wire        bus_grant_ack_n,
  output wire        chain_grant_out_n,
  // interrupt
  output wire        irq_out_n_o,
  output wire        irq_out_n_oe_n,
  // setup values
  input  wire [47:0] node_addr,
  input  wire [63:0] logic_filter,
  input  wire        promisc,
  input  wire [23:0] tx_buf_addr,
  input  wire [10:0] tx_buf_len,
  input  wire [23:0] rx_buf_addr,
  // serial link
  input  wire        tx_bit_clock,
  output wire        tx_data,
  output wire        tx_output_enable,
  input  wire        rx_bit_clock,
  input  wire        rx_data,
  input  wire        carrier_present
);
  localparam [6:0] MS_IDLE = 7'h01, MS_REQ = 7'h02, MS_ACK = 7'h04, MS_ADR = 7'h08;
  localparam [6:0] MS_DAT = 7'h10, MS_END = 7'h20, MS_REL = 7'h40;
  localparam [3:0] TS_IDLE = 4'h1, TS_PRE = 4'h2, TS_DAT = 4'h4, TS_FCS = 4'h8;
  localparam [1:0] RS_HUNT = 2'h1, RS_DAT = 2'h2;
  localparam [31:0] TMO = `LNC_TMO_CYC;

  function [5:0] inc48;
    input [5:0] p;
    inc48 = (p == `LNC_TXF_DEPTH - 6'h01) ? 6'h00 : p + 6'h01;
  endfunction

  // --------
  // state
  // --------
  reg [1:0]  rap_q;
  reg        stop_q, stop_pend_q, ien_q, bus_pin_config_bit_q, tx_busy_q, sl_q;
  reg [6:0]  flag_q;   // babble_flag, crcerr, miss, memory_error_flag, rx_done_flag, tx_done_flag, init_done_flag
  reg [15:0] sdat_q;
  reg [47:0] node_q;
  reg [63:0] filt_q;
  reg        prom_q;
  reg [6:0]  ms_q;
  reg        mwr_q;
  reg [23:0] maddr_q;
  reg [15:0] mdat_q;
  reg [31:0] tmo_q;
  reg [7:0]  txm [0:47];
  reg [5:0]  txw_q, txr_q, txc_q;
  reg [10:0] txf_q, txs_q;
  reg [7:0]  rxm [0:63];
  reg [5:0]  rxw_q, rxr_q;
  reg [6:0]  rxc_q;
  reg [23:0] rxo_q;
  reg [3:0]  ts_q;
  reg [7:0]  tsh_q;
  reg [2:0]  tbit_q;
  reg [3:0]  tbyte_q;
  reg [31:0] fcs_q;
  reg        tx_bit_clock_q, rclk_q;
  reg [1:0]  rs_q;
  reg [7:0]  rsh_q;
  reg [2:0]  rbit_q;
  reg [2:0]  rcnt_q;
  reg [39:0] dest_q;
  reg        racc_q;

  wire [6:0]  flag_set;
  wire        any_irq = |{flag_q[6], flag_q[4:0]};  // see [R16]
  wire        master  = |(ms_q & (MS_ADR | MS_DAT | MS_END));
  wire        sl_act  = !chip_select_n && !data_strobe_n_i && !master;
  wire        sl_wr   = sl_act && !sl_q && !rw_i;
  wire [15:0] main_control_status_reg    = {1'b0, flag_q, any_irq, ien_q, 2'h0, tx_busy_q, stop_q, !stop_q, 1'b0};
  wire [15:0] din     = muxed_addr_data_bus_i;
  wire tedge = tx_bit_clock && !tx_bit_clock_q;                               // see [R15]

  // --------
  // slave register access
  // --------
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rap_q       <= 2'h0;
      stop_q      <= `LNC_STOP_RST;   // see [R13]
      stop_pend_q <= 1'b0;
      ien_q       <= 1'b0;
      bus_pin_config_bit_q      <= `LNC_BUS_CONFIG_REG_RST;   // see [R7]
      tx_busy_q   <= 1'b0;
      sl_q        <= 1'b0;
      sdat_q      <= 16'h0000;
      flag_q      <= 7'h00;
      node_q      <= 48'h0;
      filt_q      <= 64'h0;
      prom_q      <= 1'b0;
    end
    else if (ce)
    begin
      sl_q <= sl_act;
      // ready stays until the strobe returns high (see [R12])
      if (sl_act && !sl_q)
        sdat_q <= port_sel ? {14'h0, rap_q} :
                  (rap_q == `LNC_IDX_MAIN_CONTROL_STATUS_REG) ? main_control_status_reg :
                  (rap_q == `LNC_IDX_BUS_CONFIG_REG) ? {15'h0, bus_pin_config_bit_q} : 16'h0000;
      // flags: a hardware set in the clear cycle wins (see [R17])
      flag_q <= (flag_q & ~((sl_wr && !port_sel && rap_q == `LNC_IDX_MAIN_CONTROL_STATUS_REG) ?
                din[`LNC_B_FLAG+6:`LNC_B_FLAG] : 7'h00)) | flag_set;
      if (sl_wr && port_sel)
        rap_q <= din[1:0];                                            // see [R24]
      if (sl_wr && !port_sel && rap_q == `LNC_IDX_BUS_CONFIG_REG && stop_q)
        bus_pin_config_bit_q <= din[`LNC_B_BUS_PIN_CONFIG_BIT];                                   // see [R7]
      if (sl_wr && !port_sel && rap_q == `LNC_IDX_MAIN_CONTROL_STATUS_REG)
      begin
        ien_q <= din[`LNC_B_IEN];
        if (din[`LNC_B_STOP])
          stop_pend_q <= 1'b1;
        else if (din[`LNC_B_INIT])
        begin
          stop_q <= 1'b0;
          node_q <= node_addr;
          filt_q <= logic_filter;
          prom_q <= promisc;
        end
        else if (din[`LNC_B_STRT])
          stop_q <= 1'b0;
        if (din[`LNC_B_TDMD] && !stop_q && !din[`LNC_B_STOP])
          tx_busy_q <= 1'b1;
      end
      // a stop takes effect only once the slave cycle has ended
      if (stop_pend_q && !sl_act && !sl_q)
      begin
        stop_q      <= 1'b1;
        stop_pend_q <= 1'b0;
      end
      if (stop_q || (ts_q == TS_FCS && tbyte_q == 4'h3 && tbit_q == 3'h7 && tedge))
        tx_busy_q <= 1'b0;
    end
  end
  assign flag_set[0] = sl_wr && !port_sel && rap_q == `LNC_IDX_MAIN_CONTROL_STATUS_REG && din[`LNC_B_INIT];

  // --------
  // bus master
  // --------
  wire rx_need = (rxc_q != 7'h00);
  wire tx_need = tx_busy_q && (txf_q != tx_buf_len) && (txc_q < `LNC_TXF_DEPTH);
  wire mem_ok  = ms_q == MS_DAT && !ready_n_i;                        // see [R11]
  wire mem_tmo = ms_q == MS_DAT && ready_n_i && tmo_q == TMO;
  assign flag_set[3] = mem_tmo;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ms_q    <= MS_IDLE;
      mwr_q   <= 1'b0;
      maddr_q <= 24'h000000;
      mdat_q  <= 16'h0000;
      tmo_q   <= 32'h0;
    end
    else if (ce)
    begin
      tmo_q <= (ms_q == MS_DAT) ? tmo_q + 32'h1 : 32'h0;
      case (ms_q)
        MS_IDLE:
          if (!stop_q && (rx_need || tx_need))
          begin
            mwr_q   <= rx_need;
            maddr_q <= rx_need ? rx_buf_addr + rxo_q : tx_buf_addr + {13'h0, txf_q};
            mdat_q  <= {8'h00, rxm[rxr_q]};
            ms_q    <= MS_REQ;
          end
        MS_REQ:
          if (chain_bus_request_n_i)
            ms_q <= MS_ACK;                                           // see [R8]
        MS_ACK:
          if (!bus_grant_ack_n)
            ms_q <= MS_ADR;                                           // see [R6]
        MS_ADR:
          ms_q <= MS_DAT;
        MS_DAT:
          if (mem_ok || mem_tmo)
          begin
            if (!mwr_q)
              mdat_q <= din;
            ms_q <= MS_END;
          end
        MS_END:
          if (ready_n_i)
            ms_q <= MS_REL;
        MS_REL:
          if (bus_grant_ack_n)
            ms_q <= MS_IDLE;                                          // see [R5]
        default:
          ms_q <= MS_IDLE;
      endcase
      if (stop_q)
        ms_q <= MS_IDLE;
    end
  end

  // hold low from request through the end of the transaction (see [R6])
  wire req_on = |(ms_q & (MS_ACK | MS_ADR | MS_DAT | MS_END));
  assign chain_bus_request_n_o    = 1'b0;
  assign chain_bus_request_n_oe_n = !req_on;
  assign chain_grant_out_n = !(bus_pin_config_bit_q && !bus_grant_ack_n && !req_on && ms_q != MS_REL);
  // see [R1]
  assign high_address_lines    = maddr_q[23:16];
  assign muxed_addr_data_bus_o = master ? ((ms_q == MS_ADR) ? maddr_q[15:0] : mdat_q) : sdat_q;
  assign muxed_addr_data_bus_oe_n = !((ms_q == MS_ADR) || (master && mwr_q) || (sl_q && rw_i));
  assign master_ctl_oe_n   = !master;                                 // see [R13]
  assign xcvr_inbound_ctl  = !(!mwr_q && ms_q != MS_ADR);             // see [R2]
  assign xcvr_outbound_ctl = !(ms_q == MS_ADR || mwr_q);              // see [R3]
  assign data_strobe_n_o   = (ms_q != MS_DAT);                        // see [R4]
  assign rw_o              = !mwr_q;                                  // see [R10]
  assign ready_n_o         = 1'b0;
  assign ready_n_oe_n      = !sl_q;                                   // see [R12]
  assign irq_out_n_o       = 1'b0;
  assign irq_out_n_oe_n    = !(any_irq && ien_q);                     // see [R9]

  // --------
  // transmit fifo and serializer
  // --------
  wire tpush = mem_ok && !mwr_q;
  wire tload = tedge && tbit_q == 3'h7;
  wire tpop  = tload && txc_q != 6'h00 &&
               ((ts_q == TS_PRE && tbyte_q == 4'h7) || ts_q == TS_DAT);
  wire [31:0] tcrc, tcrc_nxt;
  assign flag_set[1] = ts_q == TS_FCS && tbyte_q == 4'h3 && tload;
  assign flag_set[6] = tpop && txs_q == `LNC_MAX_LEN;

  lnc_crc32 u_tcrc (
    .clock   (clock),
    .rstn    (rstn),
    .ce      (ce),
    .init    (ts_q == TS_IDLE),
    .en      (tedge && ts_q == TS_DAT),
    .din     (tsh_q[0]),
    .crc_q   (tcrc),
    .crc_nxt (tcrc_nxt)
  );

  always @(posedge clock)
  begin
    if (ce && tpush)
      txm[txw_q] <= din[7:0];
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      txw_q <= 6'h00;  txr_q <= 6'h00;  txc_q <= 6'h00;
      txf_q <= 11'h000; txs_q <= 11'h000;
      ts_q  <= TS_IDLE; tsh_q <= 8'h00; tbit_q <= 3'h0; tbyte_q <= 4'h0;
      fcs_q <= 32'h0;   tx_bit_clock_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_bit_clock_q <= tx_bit_clock;
      if (ms_q == MS_END && ready_n_i && !mwr_q)
        txf_q <= txf_q + 11'h001;
      if (tpush)
        txw_q <= inc48(txw_q);
      if (tpop)
        txr_q <= inc48(txr_q);
      txc_q <= txc_q + {5'h0, tpush} - {5'h0, tpop};
      if (tedge && ts_q != TS_IDLE)
      begin
        tbit_q <= tbit_q + 3'h1;
        tsh_q  <= {1'b0, tsh_q[7:1]};
      end
      case (ts_q)
        TS_IDLE:
          if (tx_busy_q && txc_q != 6'h00 && tedge)
          begin
            ts_q <= TS_PRE;                                           // see [R19]
            tsh_q <= `LNC_PRE; tbit_q <= 3'h0; tbyte_q <= 4'h0; txs_q <= 11'h000;
          end
        TS_PRE:
          if (tload)
          begin
            tbyte_q <= tbyte_q + 4'h1;
            tsh_q   <= (tbyte_q == 4'h6) ? `LNC_SFD : `LNC_PRE;       // see [R18]
            if (tbyte_q == 4'h7)
            begin
              ts_q  <= TS_DAT;
              tsh_q <= txm[txr_q];
              txs_q <= 11'h001;
            end
          end
        TS_DAT:
          if (tload)
          begin
            if (tpop)
            begin
              tsh_q <= txm[txr_q];
              txs_q <= txs_q + 11'h001;
            end
            else
            begin
              // buffer ran dry: close the frame with its check sequence
              ts_q    <= TS_FCS;
              tbyte_q <= 4'h0;
              fcs_q   <= ~tcrc_nxt;                                   // see [R18]
              tsh_q   <= ~tcrc_nxt[7:0];
            end
          end
        TS_FCS:
          if (tload)
          begin
            tbyte_q <= tbyte_q + 4'h1;
            fcs_q   <= {8'h00, fcs_q[31:8]};
            tsh_q   <= fcs_q[15:8];
            if (tbyte_q == 4'h3)
            begin
              ts_q <= TS_IDLE;
              tsh_q <= 8'h00;
              txf_q <= 11'h000;
            end
          end
        default:
          ts_q <= TS_IDLE;
      endcase
      if (stop_q)
      begin
        ts_q <= TS_IDLE; txf_q <= 11'h000; txw_q <= 6'h00; txr_q <= 6'h00; txc_q <= 6'h00;
      end
    end
  end
  assign tx_data          = tsh_q[0];
  assign tx_output_enable = (ts_q != TS_IDLE);                        // see [R14]

  // --------
  // receive deserializer, filter and fifo
  // --------
  wire        redge = rx_bit_clock && !rclk_q && carrier_present;     // see [R15]
  wire [7:0]  rnb   = {rx_data, rsh_q[7:1]};
  wire        rbyte = redge && rs_q == RS_DAT && rbit_q == 3'h7;
  wire [47:0] rdst  = {dest_q, rnb};
  wire [31:0] rcrc, rcrc_nxt;
  wire        rend  = rs_q == RS_DAT && !carrier_present;
  wire        racc  = prom_q || rdst == node_q ||                     // see [R21]
                      rdst == 48'hFFFFFFFFFFFF ||
                      (rdst[40] && filt_q[rcrc_nxt[31:26]]);          // see [R22]
  wire        b_in_ready, b_out_valid, b_out_ready;
  wire [7:0]  b_out_data;
  wire        b_in_valid = rbyte && racc_q;
  wire        rpush = b_out_valid && b_out_ready;
  wire        rpop  = (ms_q == MS_END) && ready_n_i && mwr_q;
  assign b_out_ready = (rxc_q != 7'h40);
  assign flag_set[2] = rend && racc_q;
  assign flag_set[5] = rend && racc_q && rcrc != `LNC_RESID;          // see [R20]
  assign flag_set[4] = b_in_valid && !b_in_ready;

  lnc_crc32 u_rcrc (
    .clock   (clock),
    .rstn    (rstn),
    .ce      (ce),
    .init    (rs_q == RS_HUNT),
    .en      (redge && rs_q == RS_DAT),
    .din     (rx_data),
    .crc_q   (rcrc),
    .crc_nxt (rcrc_nxt)
  );

  lnc_buf2 u_rbuf (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (b_in_valid),
    .in_ready  (b_in_ready),
    .in_data   (rnb),
    .out_valid (b_out_valid),
    .out_ready (b_out_ready),
    .out_data  (b_out_data)
  );

  always @(posedge clock)
  begin
    if (ce && rpush)
      rxm[rxw_q] <= b_out_data;                                       // see [R20]
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rclk_q <= 1'b0; rs_q <= RS_HUNT; rsh_q <= 8'h00; rbit_q <= 3'h0;
      rcnt_q <= 3'h0; dest_q <= 40'h0; racc_q <= 1'b0;
      rxw_q  <= 6'h00; rxr_q <= 6'h00; rxc_q <= 7'h00; rxo_q <= 24'h000000;
    end
    else if (ce)
    begin
      rclk_q <= rx_bit_clock;
      if (rpush)
        rxw_q <= rxw_q + 6'h01;
      if (rpop)
      begin
        rxr_q <= rxr_q + 6'h01;
        rxo_q <= rxo_q + 24'h000001;
      end
      rxc_q <= rxc_q + {6'h0, rpush} - {6'h0, rpop};
      if (redge)
      begin
        rsh_q  <= rnb;
        rbit_q <= rbit_q + 3'h1;
      end
      if (rs_q == RS_HUNT && redge && rnb == `LNC_SFD)
      begin
        rs_q <= RS_DAT; rbit_q <= 3'h0; rcnt_q <= 3'h0; racc_q <= 1'b0;
      end
      if (rbyte && rcnt_q != 3'h6)
      begin
        rcnt_q <= rcnt_q + 3'h1;
        dest_q <= rdst[39:0];
        if (rcnt_q == 3'h5)
          racc_q <= racc;
      end
      if (rend || stop_q)
      begin
        rs_q <= RS_HUNT; rsh_q <= 8'h00; racc_q <= 1'b0;
      end
      if (stop_q)
      begin
        rxw_q <= 6'h00; rxr_q <= 6'h00; rxc_q <= 7'h00; rxo_q <= 24'h000000;
      end
    end
  end
endmodule // lnc_top

// File: test/lnc_top_monitor.sv
// --------
// bus handshake checker
// --------
module lnc_top_monitor (
  // clock and reset
  input wire clock,
  input wire rstn,
  // master pins
  input wire muxed_addr_data_bus_oe_n,
  input wire xcvr_inbound_ctl,
  input wire xcvr_outbound_ctl,
  input wire master_ctl_oe_n,
  input wire rw_o,
  input wire data_strobe_n_o,
  // slave pins
  input wire data_strobe_n_i,
  input wire chip_select_n,
  input wire ready_n_oe_n,
  // arbitration
  input wire chain_bus_request_n_i,
  input wire chain_bus_request_n_oe_n,
  input wire bus_grant_ack_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence adr_s; $fell(master_ctl_oe_n); endsequence
  sequence rd_dat_s; !master_ctl_oe_n && rw_o && !data_strobe_n_o; endsequence
  addr_phase_a: assert property (adr_s |-> data_strobe_n_o && !xcvr_outbound_ctl
    && !muxed_addr_data_bus_oe_n) else $error("bad address phase");
  strobe_order_a: assert property (adr_s |=> !data_strobe_n_o)
    else $error("strobe not low after address");
  read_data_a: assert property (rd_dat_s |-> !xcvr_inbound_ctl && xcvr_outbound_ctl
    && muxed_addr_data_bus_oe_n) else $error("bad read data phase");
  write_xcvr_a: assert property (!master_ctl_oe_n && !rw_o |-> xcvr_inbound_ctl
    && !xcvr_outbound_ctl) else $error("bad write transceiver controls");
  hold_whole_a: assert property (!master_ctl_oe_n |-> !chain_bus_request_n_oe_n)
    else $error("request dropped while master");
  re_request_a: assert property ($fell(chain_bus_request_n_oe_n) |-> $past(bus_grant_ack_n))
    else $error("request while grant low");
  sense_line_a: assert property ($fell(chain_bus_request_n_oe_n)
    |-> $past(chain_bus_request_n_i)) else $error("request on busy line");
  slave_ready_a: assert property ($fell(data_strobe_n_i) && !chip_select_n
    && master_ctl_oe_n |=> !ready_n_oe_n) else $error("no slave ready");
  ready_release_a: assert property (data_strobe_n_i && master_ctl_oe_n
    && !ready_n_oe_n |=> ready_n_oe_n) else $error("ready held too long");
endmodule // lnc_top_monitor

bind lnc_top lnc_top_monitor mon_u (.*);

// File: test/lnc_mem_model.sv
// --------
// memory and arbiter
// --------
module lnc_mem_model (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  // device master pins
  input  wire        req_oe_n,
  input  wire        mst_oe_n,
  input  wire        das_n,
  input  wire        rw,
  input  wire [15:0] dal,
  input  wire [7:0]  hi,
  // answers
  output logic        grant_n,
  output logic        ready_n,
  output wire         drv,
  output wire  [15:0] rdat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] a_q, hi_q;
  logic       s_q;
  // grant follows the request with a lag, so release is slow too
  assign drv     = !mst_oe_n && rw && !das_n;
  // garbage until ready, so early sampling shows up
  assign rdat    = ready_n ? {2{~mem[a_q]}} : {8'h00, mem[a_q]};
  logic [1:0] g_q;
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      g_q     <= 2'h3;
      s_q     <= 1'b1;
      ready_n <= 1'b1;
    end
    else
    begin
      g_q     <= {g_q[0], req_oe_n};
      s_q     <= das_n || mst_oe_n;
      ready_n <= s_q || das_n || mst_oe_n;
      if (!mst_oe_n && das_n && ready_n)
      begin
        a_q  <= dal[7:0];
        hi_q <= hi;
      end
      if (!ready_n && !das_n && !rw && !mst_oe_n)
        mem[a_q] <= dal[7:0];
    end
  always @* grant_n = g_q[1];
endmodule // lnc_mem_model

// File: test/lnc_top_tb.sv
module lnc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] lnc_bq_t[$];
  // --------
  // wiring
  // --------
  logic        clock = 1'b0, txc = 1'b0, rstn = 1'b0, rxc = 1'b0, rxd = 1'b0, carrier = 1'b0;
  logic        cs_n = 1'b1, das_n = 1'b1, psel = 1'b0, rw = 1'b0, other_rq = 1'b1;
  logic [15:0] tdat = 16'h0, cyc = 16'h0, v;
  logic [47:0] node = 48'h021122334455;
  logic [63:0] flt = 64'h0;
  logic [23:0] tba = 24'h120010, rba = 24'h000080;
  lnc_bq_t     pre = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5};
  logic        bits[$];
  int          mismatches, checked;
  wire  [15:0] bus_o, bus_i, rdat;
  wire  [7:0]  hi;
  wire         bus_oe_n, xi, xo, mst_oe_n, rw_o, das_o, rdy_o, rdy_oe_n;
  wire         rq_o, rq_oe_n, irq_oe_n, txd, txen, grant_n, mrdy_n, drv;
  // undriven bus shows a changing pattern, not its last value
  assign bus_i = !bus_oe_n ? bus_o : drv ? rdat : (!cs_n && !rw) ? tdat : cyc ^ 16'h5A5A;
  lnc_top dut_u (.clock(clock), .rstn(rstn), .ce(1'b1),
    .muxed_addr_data_bus_i(bus_i), .muxed_addr_data_bus_o(bus_o),
    .muxed_addr_data_bus_oe_n(bus_oe_n), .high_address_lines(hi),
    .xcvr_inbound_ctl(xi), .xcvr_outbound_ctl(xo), .master_ctl_oe_n(mst_oe_n),
    .rw_i(mst_oe_n ? rw : rw_o), .rw_o(rw_o),
    .data_strobe_n_i(mst_oe_n ? das_n : das_o), .data_strobe_n_o(das_o),
    .ready_n_i(mrdy_n & (rdy_oe_n | rdy_o)), .ready_n_o(rdy_o), .ready_n_oe_n(rdy_oe_n),
    .chip_select_n(cs_n), .port_sel(psel),
    .chain_bus_request_n_i((rq_oe_n | rq_o) & other_rq), .chain_bus_request_n_o(rq_o),
    .chain_bus_request_n_oe_n(rq_oe_n), .bus_grant_ack_n(grant_n), .chain_grant_out_n(),
    .irq_out_n_o(), .irq_out_n_oe_n(irq_oe_n), .node_addr(node), .logic_filter(flt),
    .promisc(1'b0), .tx_buf_addr(tba), .tx_buf_len(11'h002), .rx_buf_addr(rba),
    .tx_bit_clock(txc), .tx_data(txd), .tx_output_enable(txen),
    .rx_bit_clock(rxc), .rx_data(rxd), .carrier_present(carrier));
  lnc_mem_model mem_u (.clock(clock), .rstn(rstn), .req_oe_n(rq_oe_n),
    .mst_oe_n(mst_oe_n), .das_n(das_o), .rw(rw_o), .dal(bus_i), .hi(hi),
    .grant_n(grant_n), .ready_n(mrdy_n), .drv(drv), .rdat(rdat));
  always #4 clock = ~clock;
  always #50 txc = ~txc;
  always @(posedge clock) cyc <= cyc + 16'h0001;
  // mid-bit sampling, clear of the update after the rising edge
  always @(negedge txc) if (txen === 1'b1) bits.push_back(txd);
  task cmp(input logic [15:0] got, input logic [15:0] ex);
    checked++;
    if (got !== ex)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task acc(input logic ps, input logic rd, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    cs_n <= 1'b0;
    das_n <= 1'b0;
    psel <= ps;
    rw <= rd;
    tdat <= wd;
    @(posedge clock);
    while (rdy_oe_n !== 1'b0 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    v = bus_o;
    cs_n <= 1'b1;
    das_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task wreg(input logic [1:0] i, input logic [15:0] d);
    acc(1'b1, 1'b0, {14'h0000, i});
    acc(1'b0, 1'b0, d);
  endtask
  task rreg(input logic [1:0] i);
    acc(1'b1, 1'b0, {14'h0000, i});
    acc(1'b0, 1'b1, 16'h0000);
  endtask
  task wirq(input int lim);
    int n;
    n = 0;
    while (irq_oe_n !== 1'b0 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
  endtask
  function automatic lnc_bq_t frm(lnc_bq_t q, logic bad);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i])
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? 32'hEDB88320 : 32'h0);
    c = ~c ^ {31'h0, bad};
    return {q, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction
  // receive clock runs only inside the frame
  task rx_frame(input lnc_bq_t q);
    lnc_bq_t w;
    w = {pre, q};
    @(posedge clock);
    carrier <= 1'b1;
    foreach (w[i])
      for (int k = 0; k < 8; k++)
      begin
        rxd <= w[i][k];
        repeat (6) @(posedge clock);
        rxc <= 1'b1;
        repeat (7) @(posedge clock);
        rxc <= 1'b0;
      end
    repeat (6) @(posedge clock);
    carrier <= 1'b0;
    rxd <= ~rxd;
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // tests need about 8000 cycles
  initial
  begin
    repeat (60000) @(posedge clock);
    mismatches++;
    $display("watchdog expired");
    tally_and_finish;
  end
  initial
  begin
    lnc_bq_t    ex;
    logic [7:0] b;
    mem_u.mem[8'h10] = 8'h3C;
    mem_u.mem[8'h11] = 8'hA7;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    rreg(2'h0);
    cmp(v & 16'h00C6, 16'h0004);
    rreg(2'h3);
    cmp(v, 16'h0);
    wreg(2'h3, 16'h0001);
    rreg(2'h3);
    cmp(v, 16'h0001);
    $display("test reset done");
    wreg(2'h0, 16'h0041);
    wirq(200);
    cmp({15'h0000, irq_oe_n}, 16'h0000);
    rreg(2'h0);
    cmp(v & 16'h01C6, 16'h01C2);
    wreg(2'h0, 16'h0000);
    cmp({15'h0000, irq_oe_n}, 16'h0001);
    rreg(2'h0);
    cmp(v & 16'h00C0, 16'h0080);
    wreg(2'h3, 16'h0000);
    rreg(2'h3);
    cmp(v, 16'h0001);
    wreg(2'h0, 16'h7F40);
    cmp({15'h0000, irq_oe_n}, 16'h0001);
    $display("test status done");
    other_rq <= 1'b0;
    wreg(2'h0, 16'h0048);
    repeat (40) @(posedge clock);
    other_rq <= 1'b1;
    wirq(20000);
    repeat (16) @(posedge clock);
    ex = {pre, frm({8'h3C, 8'hA7}, 1'b0)};
    cmp(16'(bits.size()), 16'h0070);
    foreach (ex[i])
    begin
      for (int k = 0; k < 8; k++)
        b[k] = bits[8*i+k];
      cmp({8'h00, b}, {8'h00, ex[i]});
    end
    cmp({8'h00, mem_u.hi_q}, 16'h0012);
    rreg(2'h0);
    cmp(v & 16'h0200, 16'h0200);
    wreg(2'h0, 16'h7F40);
    $display("test transmit done");
    rx_frame(frm({8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h5A, 8'hC3}, 1'b0));
    wirq(5000);
    rreg(2'h0);
    cmp(v & 16'h2400, 16'h0400);
    wreg(2'h0, 16'h7F40);
    rx_frame(frm({8'h0A, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h5A, 8'hC3}, 1'b0));
    wirq(500);
    cmp({15'h0000, irq_oe_n}, 16'h0001);
    cmp({mem_u.mem[8'h81], mem_u.mem[8'h80]}, 16'hC35A);
    rx_frame(frm({8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'hC3}, 1'b1));
    wirq(5000);
    rreg(2'h0);
    cmp(v & 16'h2400, 16'h2400);
    $display("test receive done");
    tally_and_finish;
  end
endmodule // lnc_top_tb
